// *** rtl/kmm_cfg.svh ***
// Constants of the keypad memory monitor: key codes, display codes and timing.
// Behaviour
// R1: Keep the last shown address in a private register normal operation never touches.
// R2: After show-current-address, Enter shows the byte at the kept address.
// R3: Before any address entry the kept address reads as zero.
// R4: Modify key works only while a location's data is shown; otherwise no response.
// R5: Modify key is refused while a diagnostic routine runs.
// R6: Accepted modify key shows a two question mark byte prompt.
// R7: Byte digits shift into the right two positions; left two stay blank.
// R8: Enter during byte entry writes the shown byte to the current location.
// R9: A write to a read-only address leaves it unchanged, nothing else happens.
// R10: Live-watch key shows four question marks, then address entry as usual.
// R11: Enter after live-watch address shows that byte and re-reads it continuously.
// R12: The live-watch byte blinks about ten times per second.
// R13: Clear or Reset key ends live-watch and returns to idle.
// R14: Address entry prompts ????, digits shift in from the right, Enter shows byte.
// R15: Each further Enter while a byte shows advances the address and shows it.
// R16: Addresses are 16 bits as four hex digits; unused positions show blank.
`ifndef KMM_CFG_SVH
`define KMM_CFG_SVH

// Key codes on key_code: 5'h00 to 5'h0F are hex digits.
`define KMM_KEY_ENTER 5'h10
`define KMM_KEY_CLEAR 5'h11
`define KMM_KEY_RESET 5'h12
`define KMM_KEY_ADDR 5'h13
`define KMM_KEY_SHOW 5'h14
`define KMM_KEY_MODIFY 5'h15
`define KMM_KEY_PROBE 5'h16

// Display digit codes; 5'h00 to 5'h0F show a hex digit.
`define KMM_DSP_BLANK 5'h10
`define KMM_DSP_QUERY 5'h11
`define KMM_DSP_DASH 5'h12

// Reset value of the kept address.
`define KMM_ADDR_RESET 16'h0000

// Blink timing: half period of the live-watch flash at the 125 MHz clock.
`define KMM_CLK_KHZ 125000
`define KMM_BLINK_HALF_MS 50
`define KMM_BLINK_HALF_CYC (`KMM_BLINK_HALF_MS * `KMM_CLK_KHZ)

`endif

// *** rtl/kmm_pkg.sv ***
// Types shared by the keypad memory monitor.
package kmm_pkg;
	typedef logic [4:0] kmm_code_t;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR_PROMPT, ST_ADDR_ENTRY, ST_SHOW_ADDR, ST_READ, ST_WAIT, ST_DATA,
		ST_BYTE_PROMPT, ST_BYTE_ENTRY, ST_PROBE_PROMPT, ST_PROBE_ENTRY, ST_PROBE
	} kmm_state_e;
endpackage

// *** rtl/kmm_hex_shift.sv ***
// Hex digit entry register: each digit shifts in from the right.
`timescale 1ns/10ps
`default_nettype none
module kmm_hex_shift (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic clear,
	input wire logic shift,
	input wire logic [3:0] digit,
	output logic [15:0] value_q
);
	logic [15:0] value_d;

	// Clear has priority so a prompt always starts from zero.
	assign value_d = clear ? 16'h0000 : (shift ? {value_q[11:0], digit} : value_q);

	// Entry register, frozen while the clock enable is low.
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			value_q <= 16'h0000;
		else if (clk_en)
			value_q <= value_d;
	end
endmodule
`default_nettype wire

// *** rtl/kmm_blink.sv ***
// Blink timer for the live-watch display.
`timescale 1ns/10ps
`default_nettype none
`include "kmm_cfg.svh"
module kmm_blink #(
	parameter int unsigned HALF_CYC = `KMM_BLINK_HALF_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic run,
	output logic show_q
);
	logic [22:0] cnt_q;
	logic wrap;

	assign wrap = (cnt_q == 23'(HALF_CYC - 1));

	// The byte starts visible each time watching starts, so the first value is seen at once.
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cnt_q <= 23'h000000;
			show_q <= 1'b1;
		end
		else if (clk_en)
		begin
			if (!run)
			begin
				cnt_q <= 23'h000000;
				show_q <= 1'b1;
			end
			else if (wrap)
			begin
				cnt_q <= 23'h000000;
				show_q <= !show_q; // [R12]
			end
			else
				cnt_q <= cnt_q + 23'h000001;
		end
	end
endmodule
`default_nettype wire

// *** rtl/kmm_monitor.sv ***
// Keypad memory monitor: address entry, recall, byte modify and live watch.
`timescale 1ns/10ps
`default_nettype none
`include "kmm_cfg.svh"
module kmm_monitor #(
	parameter int unsigned BLINK_HALF_CYC = `KMM_BLINK_HALF_CYC
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	input wire logic key_valid,
	input wire logic [4:0] key_code,
	input wire logic diag_active,
	output logic [15:0] mem_addr,
	output logic mem_rd_en,
	input wire logic [7:0] mem_rdata,
	output logic mem_wr_en,
	output logic [7:0] mem_wdata,
	input wire logic mem_ro,
	output logic [19:0] disp_q
);
	kmm_pkg::kmm_state_e state_q;
	kmm_pkg::kmm_state_e state_d;
	logic [15:0] cur_addr_q;
	logic [15:0] cur_addr_d;
	logic [7:0] data_q;
	logic rd_pend_q;
	logic [15:0] entry_q;
	logic entry_clear;
	logic entry_shift;
	logic blink_show;
	logic [19:0] disp_d;
	logic [19:0] ent_codes;
	logic [19:0] adr_codes;
	logic [9:0] dat_codes;
	logic [9:0] left_blank;

	// Decoded key strobes; every key takes effect only in an enabled cycle.
	wire key_hit = clk_en && key_valid;
	wire is_digit = key_hit && !key_code[4];
	wire is_enter = key_hit && key_code == `KMM_KEY_ENTER;
	wire is_clear = key_hit && key_code == `KMM_KEY_CLEAR;
	wire is_reset = key_hit && key_code == `KMM_KEY_RESET;
	wire is_addr = key_hit && key_code == `KMM_KEY_ADDR;
	wire is_show = key_hit && key_code == `KMM_KEY_SHOW;
	wire is_modify = key_hit && key_code == `KMM_KEY_MODIFY;
	wire is_probe = key_hit && key_code == `KMM_KEY_PROBE;

	// Function keys start a new sequence only from a resting display.
	wire fn_ok = state_q == kmm_pkg::ST_IDLE || state_q == kmm_pkg::ST_DATA
		|| state_q == kmm_pkg::ST_SHOW_ADDR;
	wire in_entry = state_q == kmm_pkg::ST_ADDR_ENTRY || state_q == kmm_pkg::ST_PROBE_ENTRY;
	wire in_byte = state_q == kmm_pkg::ST_BYTE_ENTRY;
	wire modify_ok = state_q == kmm_pkg::ST_DATA && !diag_active; // [R4] [R5]
	wire write_hit = in_byte && is_enter;

	// Entry register control: cleared on reaching any prompt, shifted by digits.
	assign entry_clear = clk_en && (state_d == kmm_pkg::ST_ADDR_PROMPT
		|| state_d == kmm_pkg::ST_PROBE_PROMPT || state_d == kmm_pkg::ST_BYTE_PROMPT);
	assign entry_shift = is_digit && (state_d == kmm_pkg::ST_ADDR_ENTRY
		|| state_d == kmm_pkg::ST_PROBE_ENTRY || state_d == kmm_pkg::ST_BYTE_ENTRY); // [R7] [R14]

	kmm_hex_shift u_entry (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.clear(entry_clear),
		.shift(entry_shift),
		.digit(key_code[3:0]),
		.value_q(entry_q)
	);

	kmm_blink #(
		.HALF_CYC(BLINK_HALF_CYC)
	) u_blink (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.run(state_q == kmm_pkg::ST_PROBE),
		.show_q(blink_show)
	);

	// Memory port: reads are one cycle latency; the address is the kept address.
	assign mem_addr = cur_addr_q;
	assign mem_rd_en = clk_en && (state_q == kmm_pkg::ST_READ
		|| state_q == kmm_pkg::ST_PROBE); // [R11]
	// A read-only target simply sees no write strobe, so nothing else changes.
	assign mem_wr_en = write_hit && !mem_ro; // [R8] [R9]
	assign mem_wdata = entry_q[7:0];

	// Hex display codes of the three values that may be shown.
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_dig
			assign ent_codes[gi*5 +: 5] = {1'b0, entry_q[gi*4 +: 4]};
			assign adr_codes[gi*5 +: 5] = {1'b0, cur_addr_q[gi*4 +: 4]};
		end
	endgenerate
	assign dat_codes = {1'b0, data_q[7:4], 1'b0, data_q[3:0]};
	assign left_blank = {`KMM_DSP_BLANK, `KMM_DSP_BLANK};

	// Next state and next kept address.
	always_comb
	begin
		state_d = state_q;
		cur_addr_d = cur_addr_q;
		if (is_reset)
			state_d = kmm_pkg::ST_IDLE; // [R13]
		else
		begin
			unique case (state_q)
				kmm_pkg::ST_IDLE, kmm_pkg::ST_SHOW_ADDR, kmm_pkg::ST_DATA:
				begin
					if (is_addr)
						state_d = kmm_pkg::ST_ADDR_PROMPT;
					else if (is_show)
						state_d = kmm_pkg::ST_SHOW_ADDR;
					else if (is_probe)
						state_d = kmm_pkg::ST_PROBE_PROMPT; // [R10]
					else if (is_clear)
						state_d = kmm_pkg::ST_IDLE;
					else if (is_modify && modify_ok)
						state_d = kmm_pkg::ST_BYTE_PROMPT; // [R4] [R6]
					else if (is_enter && state_q == kmm_pkg::ST_SHOW_ADDR)
						state_d = kmm_pkg::ST_READ; // [R2]
					else if (is_enter && state_q == kmm_pkg::ST_DATA)
					begin
						cur_addr_d = cur_addr_q + 16'h0001; // [R15]
						state_d = kmm_pkg::ST_READ;
					end
				end
				kmm_pkg::ST_ADDR_PROMPT, kmm_pkg::ST_PROBE_PROMPT:
				begin
					if (is_clear)
						state_d = kmm_pkg::ST_IDLE;
					else if (is_digit)
						state_d = state_q == kmm_pkg::ST_ADDR_PROMPT ? kmm_pkg::ST_ADDR_ENTRY
							: kmm_pkg::ST_PROBE_ENTRY;
					else if (is_enter)
						state_d = state_q == kmm_pkg::ST_ADDR_PROMPT ? kmm_pkg::ST_READ
							: kmm_pkg::ST_PROBE;
				end
				kmm_pkg::ST_ADDR_ENTRY, kmm_pkg::ST_PROBE_ENTRY:
				begin
					if (is_clear)
						state_d = state_q == kmm_pkg::ST_ADDR_ENTRY ? kmm_pkg::ST_ADDR_PROMPT
							: kmm_pkg::ST_PROBE_PROMPT;
					else if (is_enter)
					begin
						cur_addr_d = entry_q; // [R1] [R14]
						state_d = state_q == kmm_pkg::ST_ADDR_ENTRY ? kmm_pkg::ST_READ
							: kmm_pkg::ST_PROBE; // [R11]
					end
				end
				kmm_pkg::ST_READ:
					state_d = kmm_pkg::ST_WAIT;
				kmm_pkg::ST_WAIT:
					state_d = kmm_pkg::ST_DATA;
				kmm_pkg::ST_BYTE_PROMPT:
				begin
					if (is_clear)
						state_d = kmm_pkg::ST_IDLE;
					else if (is_digit)
						state_d = kmm_pkg::ST_BYTE_ENTRY;
				end
				kmm_pkg::ST_BYTE_ENTRY:
				begin
					if (is_clear)
						state_d = kmm_pkg::ST_BYTE_PROMPT;
					else if (is_enter)
						state_d = kmm_pkg::ST_READ; // Re-read shows what really stuck.
				end
				kmm_pkg::ST_PROBE:
				begin
					if (is_clear)
						state_d = kmm_pkg::ST_IDLE; // [R13]
				end
				default:
					state_d = kmm_pkg::ST_IDLE;
			endcase
		end
	end

	// Display contents; positions not in use are blank.
	always_comb
	begin
		unique case (state_q)
			kmm_pkg::ST_ADDR_PROMPT, kmm_pkg::ST_PROBE_PROMPT:
				disp_d = {4{`KMM_DSP_QUERY}}; // [R10] [R14]
			kmm_pkg::ST_ADDR_ENTRY, kmm_pkg::ST_PROBE_ENTRY:
				disp_d = ent_codes;
			kmm_pkg::ST_SHOW_ADDR:
				disp_d = adr_codes; // [R3] [R16]
			kmm_pkg::ST_READ, kmm_pkg::ST_WAIT:
				disp_d = disp_q;
			kmm_pkg::ST_DATA:
				disp_d = {left_blank, dat_codes}; // [R16]
			kmm_pkg::ST_BYTE_PROMPT:
				disp_d = {left_blank, `KMM_DSP_QUERY, `KMM_DSP_QUERY}; // [R6]
			kmm_pkg::ST_BYTE_ENTRY:
				disp_d = {left_blank, ent_codes[9:0]}; // [R7]
			kmm_pkg::ST_PROBE:
				disp_d = {left_blank, blink_show ? dat_codes : left_blank}; // [R12]
			default:
				disp_d = {4{`KMM_DSP_DASH}};
		endcase
	end

	// Control state; the kept address is touched only by this monitor's own keys.
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= kmm_pkg::ST_IDLE;
			cur_addr_q <= `KMM_ADDR_RESET; // [R3]
		end
		else if (clk_en)
		begin
			state_q <= state_d;
			cur_addr_q <= cur_addr_d; // [R1]
		end
	end

	// Read data capture; in live watch a fresh byte lands every cycle.
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rd_pend_q <= 1'b0;
			data_q <= 8'h00;
		end
		else if (clk_en)
		begin
			rd_pend_q <= mem_rd_en;
			if (rd_pend_q)
				data_q <= mem_rdata; // [R11]
		end
	end

	// Registered display, idle dashes after reset.
	always_ff @(posedge ref_clk or posedge sys_rst)
	begin
		if (sys_rst)
			disp_q <= {4{`KMM_DSP_DASH}};
		else if (clk_en)
			disp_q <= disp_d;
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst || !clk_en);

	// Live watch is left out here, because its display changes on its own as it blinks and re-reads.
	a_modify_no_response: assert property ( // [R4]
		(is_modify && !modify_ok && state_q != kmm_pkg::ST_IDLE
			&& state_q != kmm_pkg::ST_SHOW_ADDR && state_q != kmm_pkg::ST_DATA
			&& state_q != kmm_pkg::ST_READ && state_q != kmm_pkg::ST_WAIT
			&& state_q != kmm_pkg::ST_PROBE)
		|=> $stable(state_q) ##1 $stable(disp_q))
		else $error("modify key changed a non-data display");

	a_modify_diag_refused: assert property ( // [R5]
		(is_modify && state_q == kmm_pkg::ST_DATA && diag_active)
		|=> state_q == kmm_pkg::ST_DATA ##1 disp_q[9:5] != `KMM_DSP_QUERY)
		else $error("modify accepted during diagnostic");

	a_byte_prompt_shown: assert property ( // [R6]
		(is_modify && modify_ok)
		|=> ##1 disp_q == {left_blank, `KMM_DSP_QUERY, `KMM_DSP_QUERY})
		else $error("byte prompt not shown");

	a_byte_write_data: assert property ( // [R8]
		(write_hit && !mem_ro)
		|-> mem_wr_en && mem_wdata == entry_q[7:0] && mem_addr == cur_addr_q)
		else $error("byte write missing or wrong");

	a_ro_no_write: assert property ( // [R9]
		(write_hit && mem_ro) |-> !mem_wr_en ##1 state_q == kmm_pkg::ST_READ)
		else $error("read-only location was written");

	a_show_addr_value: assert property ( // [R3]
		(is_show && fn_ok && !is_reset) |=> ##1 disp_q == adr_codes)
		else $error("kept address not shown");

	a_next_location: assert property ( // [R15]
		(is_enter && state_q == kmm_pkg::ST_DATA)
		|=> cur_addr_q == $past(cur_addr_q) + 16'h0001 && mem_rd_en)
		else $error("enter did not advance address");

	a_byte_left_blank: assert property ( // [R7]
		(in_byte && is_digit) |=> ##1 disp_q[19:10] == left_blank)
		else $error("left digits not blank in byte entry");

	a_probe_rereads: assert property ( // [R11]
		(state_q == kmm_pkg::ST_PROBE) |-> mem_rd_en ##1 rd_pend_q)
		else $error("live watch stopped reading");

	a_probe_clear_idle: assert property ( // [R13]
		(state_q == kmm_pkg::ST_PROBE && is_clear)
		|=> state_q == kmm_pkg::ST_IDLE ##1 disp_q == {4{`KMM_DSP_DASH}})
		else $error("clear did not end live watch");

	a_entry_shift_in: assert property ( // [R14]
		(in_entry && is_digit) |=> entry_q == {$past(entry_q[11:0]), $past(key_code[3:0])})
		else $error("address digit not shifted in");
endmodule
`default_nettype wire

// *** bench/kmm_mem_model.sv ***
// Controller memory model that answers the monitor's read and write strobes.
`timescale 1ns/10ps
`default_nettype none
module kmm_mem_model (
	input wire logic ref_clk,
	input wire logic [15:0] mem_addr,
	input wire logic mem_rd_en,
	output logic [7:0] mem_rdata,
	input wire logic mem_wr_en,
	input wire logic [7:0] mem_wdata,
	output logic mem_ro
);
	logic [7:0] mem [0:255];
	wire logic [7:0] idx = mem_addr[7:0];

	// Each byte starts as its index plus 3C so every location is distinct.
	initial
	begin
		for (int i = 0; i < 256; i++)
			mem[i] = 8'(i + 8'h3C);
	end

	// The upper half of the map is read-only; a stray write there still lands.
	assign mem_ro = mem_addr[15];

	// Read data arrives one cycle after the strobe; otherwise it shows junk.
	always @(posedge ref_clk)
	begin
		if (mem_wr_en)
			mem[idx] <= mem_wdata;
		if (mem_rd_en)
			mem_rdata <= mem[idx];
		else
			mem_rdata <= ~mem_rdata;
	end
endmodule
`default_nettype wire

// *** bench/keypad_memory_monitor_tb.sv ***
// Self-checking bench for the keypad memory monitor.
`timescale 1ns/10ps
`default_nettype none
`include "kmm_cfg.svh"
module keypad_memory_monitor_tb;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic key_valid = 1'b0;
	logic [4:0] key_code = 5'h00;
	logic diag_active = 1'b0;
	logic clk_en = 1'b1;
	logic [15:0] mem_addr;
	logic mem_rd_en;
	logic [7:0] mem_rdata;
	logic mem_wr_en;
	logic [7:0] mem_wdata;
	logic mem_ro;
	logic [19:0] disp_q;
	int miscompares = 0;
	int n_checks = 0;
	int cycles = 0;
	localparam logic [4:0] BL = `KMM_DSP_BLANK;
	localparam logic [4:0] QM = `KMM_DSP_QUERY;
	localparam logic [19:0] IDLE = {4{`KMM_DSP_DASH}};
	localparam logic [19:0] PR4 = {4{`KMM_DSP_QUERY}};

	kmm_monitor #(.BLINK_HALF_CYC(8)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.clk_en(clk_en), .key_valid(key_valid), .key_code(key_code),
		.diag_active(diag_active), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
		.mem_rdata(mem_rdata), .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata),
		.mem_ro(mem_ro), .disp_q(disp_q));
	kmm_mem_model mem_m (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
		.mem_rdata(mem_rdata), .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata),
		.mem_ro(mem_ro));

	// The clock runs at 125 MHz.
	initial
	begin
		forever #4 ref_clk = ~ref_clk;
	end

	// A hang is cut short well past the length of all tests together.
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			miscompares++;
			conclude();
		end
	end

	// Display code of one hex digit.
	function automatic logic [4:0] h(input logic [3:0] n);
		return {1'b0, n};
	endfunction

	// Expected display of the byte at an address, two blanks on the left.
	function automatic logic [19:0] byte_at(input logic [7:0] a);
		logic [7:0] b;
		b = a + 8'h3C;
		return {BL, BL, h(b[7:4]), h(b[3:0])};
	endfunction

	// One key pulse, then enough cycles for any read and display update.
	task automatic key(input logic [4:0] c);
		@(negedge ref_clk);
		key_valid = 1'b1;
		key_code = c;
		@(negedge ref_clk);
		key_valid = 1'b0;
		repeat (6) @(negedge ref_clk);
	endtask

	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Kept address reads zero after power-up and recalls location 0000.
	task automatic t_show_reset();
		chk("idle display", IDLE, disp_q);
		key(`KMM_KEY_SHOW);
		chk("kept address", {4{h(4'h0)}}, disp_q);
		key(`KMM_KEY_ENTER);
		chk("recalled byte", byte_at(8'h00), disp_q);
		$display("test show_reset done");
	endtask

	// Address entry, stepping with Enter, and recall of the last shown address.
	task automatic t_addr();
		key(`KMM_KEY_ADDR);
		chk("address prompt", PR4, disp_q);
		key(5'h01);
		chk("first digit", {h(4'h0), h(4'h0), h(4'h0), h(4'h1)}, disp_q);
		key(5'h02);
		chk("second digit", {h(4'h0), h(4'h0), h(4'h1), h(4'h2)}, disp_q);
		key(`KMM_KEY_ENTER);
		chk("byte 0012", byte_at(8'h12), disp_q);
		key(`KMM_KEY_ENTER);
		chk("byte 0013", byte_at(8'h13), disp_q);
		key(`KMM_KEY_CLEAR);
		key(`KMM_KEY_SHOW);
		chk("kept 0013", {h(4'h0), h(4'h0), h(4'h1), h(4'h3)}, disp_q);
		key(`KMM_KEY_ENTER);
		$display("test addr done");
	endtask

	// Byte modify at 0013 with one digit too many.
	task automatic t_modify();
		key(`KMM_KEY_MODIFY);
		chk("byte prompt", {BL, BL, QM, QM}, disp_q);
		key(5'h01);
		key(5'h02);
		key(5'h03);
		chk("byte entry", {BL, BL, h(4'h2), h(4'h3)}, disp_q);
		key(`KMM_KEY_ENTER);
		chk("written byte", {BL, BL, h(4'h2), h(4'h3)}, disp_q);
		chk("memory 0013", {12'h000, 8'h23}, {12'h000, mem_m.mem[8'h13]});
		$display("test modify done");
	endtask

	// Modify is ignored in idle and while a diagnostic runs.
	task automatic t_refuse();
		key(`KMM_KEY_CLEAR);
		key(`KMM_KEY_MODIFY);
		chk("modify in idle", IDLE, disp_q);
		key(`KMM_KEY_SHOW);
		key(`KMM_KEY_ENTER);
		diag_active = 1'b1;
		key(`KMM_KEY_MODIFY);
		chk("modify in diag", {BL, BL, h(4'h2), h(4'h3)}, disp_q);
		diag_active = 1'b0;
		$display("test refuse done");
	endtask

	// Keys given while the clock enable is low leave display and kept address alone.
	task automatic t_freeze();
		clk_en = 1'b0;
		key(`KMM_KEY_ADDR);
		key(5'h05);
		key(`KMM_KEY_ENTER);
		clk_en = 1'b1;
		chk("frozen display", {BL, BL, h(4'h2), h(4'h3)}, disp_q);
		key(`KMM_KEY_SHOW);
		chk("kept after freeze", {h(4'h0), h(4'h0), h(4'h1), h(4'h3)}, disp_q);
		$display("test freeze done");
	endtask

	// A write to read-only 8000 must not reach memory; modify at a prompt is ignored.
	task automatic t_ro();
		key(`KMM_KEY_CLEAR);
		key(`KMM_KEY_ADDR);
		key(`KMM_KEY_MODIFY);
		chk("modify at prompt", PR4, disp_q);
		key(5'h08);
		key(5'h00);
		key(5'h00);
		key(5'h00);
		key(`KMM_KEY_ENTER);
		key(`KMM_KEY_MODIFY);
		key(5'h05);
		key(5'h05);
		key(`KMM_KEY_ENTER);
		chk("read-only byte", byte_at(8'h00), disp_q);
		$display("test read_only done");
	endtask

	// Live watch on 0040, ended by Clear and then by the Reset key.
	task automatic t_probe(input logic [4:0] stop);
		logic seen_blank;
		logic seen_new;
		seen_blank = 1'b0;
		seen_new = 1'b0;
		mem_m.mem[8'h40] = 8'h7C;
		key(`KMM_KEY_PROBE);
		chk("watch prompt", PR4, disp_q);
		key(5'h04);
		key(5'h00);
		key(`KMM_KEY_ENTER);
		mem_m.mem[8'h40] = 8'h99;
		repeat (40)
		begin
			@(negedge ref_clk);
			if (disp_q === {BL, BL, BL, BL})
				seen_blank = 1'b1;
			if (disp_q === {BL, BL, h(4'h9), h(4'h9)})
				seen_new = 1'b1;
		end
		chk("watch refresh", 20'h1, {19'h0, seen_new});
		chk("watch blink", 20'h1, {19'h0, seen_blank});
		key(stop);
		chk("watch end", IDLE, disp_q);
		$display("test probe done");
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Reset for 20 cycles, then every test in turn.
	initial
	begin
		repeat (20) @(negedge ref_clk);
		sys_rst = 1'b0;
		repeat (2) @(negedge ref_clk);
		t_show_reset();
		t_addr();
		t_modify();
		t_refuse();
		t_freeze();
		t_ro();
		key(`KMM_KEY_CLEAR);
		t_probe(`KMM_KEY_CLEAR);
		t_probe(`KMM_KEY_RESET);
		conclude();
	end
endmodule
`default_nettype wire
